// ### mcs_pkg.sv
// Function
// - Eight current input channels are each converted, corrected and reported on their own through one shared path.
// - Each channel has an input selector that passes either its precision reference or its field input onward.
// - A channel multiplexer routes exactly one channel at a time to a 16-bit converter.
// - Each corrected result is written to a dual-port memory that the host reads without the controller.
// - Each raw sample is multiplied by its channel scale and then has its channel offset added before storing.
// - Scale and offset of a channel are recomputed from that channel's reference reading.
// - Once a minute, while no field input is being converted, every channel's reference is selected and converted.
// - A reference reading outside the channel's lower or upper limit sets that channel's fault flag.
// - The host broadcasts a key of due rate groups and only channels of those groups are updated.
// - The lamp goes off only after the power-on self-test passed and the host finished initialization.
// - A failed diagnostic keeps the lamp lit, and initialization does not clear it.
// - The single red lamp is lit whenever any channel fault or a board fault is present.
package mcs_pkg;
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int SAMPLE_W = 16;
    localparam int GROUP_W = 3;
    localparam int KEY_W = 8;
    localparam int SCALE_FRAC = 14;
    localparam int OFS_W = 19;
    localparam logic [15:0] REF_NOMINAL = 16'h4000;
    localparam logic [15:0] SCALE_TWO = 16'h8000;
    localparam logic [15:0] SCALE_RST = 16'h4000;
    localparam logic [18:0] OFFSET_RST = 19'h00000;
    localparam logic [15:0] LIMIT_LO_RST = 16'h3800;
    localparam logic [15:0] LIMIT_HI_RST = 16'h4800;
    localparam logic [2:0] GROUP_RST = 3'h0;
    localparam int CLK_HZ = 25000000;
    localparam int CAL_PERIOD_S = 60;
    localparam int CAL_PERIOD_CYC = CLK_HZ * CAL_PERIOD_S;
    localparam int CAL_CNT_W = 31;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE} mcs_state_t;
endpackage : mcs_pkg

// ### mcs_result_ram.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_result_ram #(
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter int DW = 16
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // Write port for the controller, registered read port for the host
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in)
        begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule : mcs_result_ram
`default_nettype wire

// ### mcs_scanner.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_scanner #(
    parameter int CAL_CYCLES = mcs_pkg::CAL_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [mcs_pkg::SAMPLE_W-1:0] adc_data_in,
    input wire logic adc_valid_in,
    input wire logic board_fault_in,
    input wire logic cfg_we_in,
    input wire logic [mcs_pkg::CH_W-1:0] cfg_chan_in,
    input wire logic [mcs_pkg::GROUP_W-1:0] cfg_group_in,
    input wire logic [mcs_pkg::SAMPLE_W-1:0] cfg_lim_lo_in,
    input wire logic [mcs_pkg::SAMPLE_W-1:0] cfg_lim_hi_in,
    input wire logic key_valid_in,
    input wire logic [mcs_pkg::KEY_W-1:0] key_in,
    input wire logic lamp_on_in,
    input wire logic diag_fail_in,
    input wire logic init_done_in,
    input wire logic [mcs_pkg::NUM_CH-1:0] fault_clr_in,
    input wire logic host_rd_en_in,
    input wire logic [mcs_pkg::CH_W-1:0] host_rd_addr_in,
    output logic [mcs_pkg::SAMPLE_W-1:0] host_rd_data_out,
    output logic host_rd_valid_out,
    output logic [mcs_pkg::CH_W-1:0] chan_sel_out,
    output logic [mcs_pkg::NUM_CH-1:0] ref_sel_out,
    output logic conv_start_out,
    output logic [mcs_pkg::NUM_CH-1:0] fault_flags_out,
    output logic lamp_out
);
    import mcs_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [17:0] mul_q14(input logic [15:0] a,
                                            input logic [15:0] s);
        logic [31:0] p;
        p = a * s;
        return p[31:SCALE_FRAC];
    endfunction : mul_q14

    function automatic logic [CH_W-1:0] first_set(
        input logic [NUM_CH-1:0] m);
        logic [CH_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                idx = CH_W'(i);
            end
        end
        return idx;
    endfunction : first_set

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic valid_s1_reg, valid_s2_reg, valid_s3_reg;
    logic bfault_s1_reg, bfault_s2_reg;
    logic [SAMPLE_W-1:0] data_s1_reg, data_s2_reg;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            valid_s1_reg <= 1'b0;
            valid_s2_reg <= 1'b0;
            valid_s3_reg <= 1'b0;
            bfault_s1_reg <= 1'b0;
            bfault_s2_reg <= 1'b0;
            data_s1_reg <= 16'h0000;
            data_s2_reg <= 16'h0000;
        end
        else
        begin
            valid_s1_reg <= adc_valid_in;
            valid_s2_reg <= valid_s1_reg;
            valid_s3_reg <= valid_s2_reg;
            bfault_s1_reg <= board_fault_in;
            bfault_s2_reg <= bfault_s1_reg;
            data_s1_reg <= adc_data_in;
            data_s2_reg <= data_s1_reg;
        end
    end

    wire adc_done = valid_s2_reg & ~valid_s3_reg;

    // ----------------------------------------------------------------
    // Per-channel configuration and calibration
    // ----------------------------------------------------------------
    logic [GROUP_W-1:0] group_reg [NUM_CH];
    logic [SAMPLE_W-1:0] lim_lo_reg [NUM_CH];
    logic [SAMPLE_W-1:0] lim_hi_reg [NUM_CH];
    logic [SAMPLE_W-1:0] scale_reg [NUM_CH];
    logic [OFS_W-1:0] offset_reg [NUM_CH];

    mcs_state_t state_reg;
    logic [CH_W-1:0] chan_reg;
    logic cal_mode_reg, cal_due_reg, post_active_reg;
    logic [SAMPLE_W-1:0] sample_reg;
    logic [NUM_CH-1:0] pend_reg, faults_reg;
    logic [CAL_CNT_W-1:0] cal_cnt_reg;
    logic lamp_hold_reg, init_seen_reg, post_done_reg, post_fail_reg;
    logic diag_fail_reg;

    // Rate-group key selects channels whose group bit is set
    logic [NUM_CH-1:0] key_mask;
    always_comb
    begin
        key_mask = '0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            key_mask[c] = key_valid_in & key_in[group_reg[c]];
        end
    end

    // Correction of a field sample, saturated to the 16-bit range
    wire [17:0] scaled = mul_q14(sample_reg, scale_reg[chan_reg]);
    wire signed [19:0] corr_sum = $signed({2'b00, scaled})
        + $signed({offset_reg[chan_reg][OFS_W-1], offset_reg[chan_reg]});
    wire [SAMPLE_W-1:0] corr_val = corr_sum[19] ? 16'h0000
        : (corr_sum[18:16] != 3'h0) ? 16'hffff : corr_sum[15:0];

    // New calibration: first-order reciprocal gain, residual offset
    wire [SAMPLE_W-1:0] new_scale = SCALE_TWO - sample_reg;
    wire [17:0] ref_scaled = mul_q14(sample_reg, new_scale);
    wire [OFS_W-1:0] new_offset = {3'b000, REF_NOMINAL}
        - {1'b0, ref_scaled};

    wire storing = (state_reg == ST_STORE);
    wire ref_bad = (sample_reg < lim_lo_reg[chan_reg])
        | (sample_reg > lim_hi_reg[chan_reg]);
    wire cal_fault = storing & cal_mode_reg & ref_bad;
    wire [NUM_CH-1:0] fault_set = cal_fault
        ? (NUM_CH'(1) << chan_reg) : '0;
    wire [NUM_CH-1:0] pend_clr = (storing & ~cal_mode_reg)
        ? (NUM_CH'(1) << chan_reg) : '0;
    wire [NUM_CH-1:0] pend_next = (pend_reg & ~pend_clr) | key_mask;
    wire [NUM_CH-1:0] faults_next = (faults_reg
        & ~(fault_clr_in | {NUM_CH{init_done_in}})) | fault_set;
    wire cal_tick = (cal_cnt_reg == CAL_CNT_W'(CAL_CYCLES - 1));
    wire last_ch = (chan_reg == CH_W'(NUM_CH - 1));
    wire pass_end = storing & cal_mode_reg & last_ch;
    wire post_fail_next = post_fail_reg | (post_active_reg & cal_fault);
    wire diag_fail_next = diag_fail_reg | diag_fail_in;
    wire lamp_release = init_seen_reg & post_done_reg & ~post_fail_reg
        & ~diag_fail_reg;
    wire lamp_hold_next = lamp_on_in | (lamp_hold_reg & ~lamp_release);
    wire lamp_next = lamp_hold_next | (|faults_next) | bfault_s2_reg
        | post_fail_next | diag_fail_next;

    // ----------------------------------------------------------------
    // Configuration and calibration storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                group_reg[c] <= GROUP_RST;
                lim_lo_reg[c] <= LIMIT_LO_RST;
                lim_hi_reg[c] <= LIMIT_HI_RST;
                scale_reg[c] <= SCALE_RST;
                offset_reg[c] <= OFFSET_RST;
            end
        end
        else
        begin
            if (cfg_we_in)
            begin
                group_reg[cfg_chan_in] <= cfg_group_in;
                lim_lo_reg[cfg_chan_in] <= cfg_lim_lo_in;
                lim_hi_reg[cfg_chan_in] <= cfg_lim_hi_in;
            end
            if (storing && cal_mode_reg && !ref_bad)
            begin
                scale_reg[chan_reg] <= new_scale;
                offset_reg[chan_reg] <= new_offset;
            end
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= ST_IDLE;
            chan_reg <= '0;
            cal_mode_reg <= 1'b0;
            cal_due_reg <= 1'b1;
            post_active_reg <= 1'b1;
            sample_reg <= 16'h0000;
            ref_sel_out <= '0;
            conv_start_out <= 1'b0;
            chan_sel_out <= '0;
            cal_cnt_reg <= '0;
        end
        else
        begin
            conv_start_out <= 1'b0;
            cal_cnt_reg <= cal_tick ? '0 : cal_cnt_reg + 1'b1;
            if (cal_tick)
            begin
                cal_due_reg <= 1'b1;
            end
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cal_due_reg && pend_reg == '0)
                    begin
                        cal_mode_reg <= 1'b1;
                        cal_due_reg <= cal_tick;
                        chan_reg <= '0;
                        ref_sel_out <= '1;
                        state_reg <= ST_START;
                    end
                    else if (pend_reg != '0)
                    begin
                        cal_mode_reg <= 1'b0;
                        chan_reg <= first_set(pend_reg);
                        ref_sel_out <= '0;
                        state_reg <= ST_START;
                    end
                end
                ST_START:
                begin
                    chan_sel_out <= chan_reg;
                    conv_start_out <= 1'b1;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (adc_done)
                    begin
                        sample_reg <= data_s2_reg;
                        state_reg <= ST_STORE;
                    end
                end
                ST_STORE:
                begin
                    if (cal_mode_reg && !last_ch)
                    begin
                        chan_reg <= chan_reg + 1'b1;
                        state_reg <= ST_START;
                    end
                    else
                    begin
                        if (pass_end)
                        begin
                            ref_sel_out <= '0;
                            cal_mode_reg <= 1'b0;
                            post_active_reg <= 1'b0;
                        end
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Scheduling, fault flags and lamp
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pend_reg <= '0;
            faults_reg <= '0;
            lamp_hold_reg <= 1'b1;
            init_seen_reg <= 1'b0;
            post_done_reg <= 1'b0;
            post_fail_reg <= 1'b0;
            diag_fail_reg <= 1'b0;
            lamp_out <= 1'b1;
            host_rd_valid_out <= 1'b0;
        end
        else
        begin
            pend_reg <= pend_next;
            faults_reg <= faults_next;
            lamp_hold_reg <= lamp_hold_next;
            init_seen_reg <= init_done_in | (init_seen_reg & ~lamp_on_in);
            post_done_reg <= post_done_reg | (pass_end & post_active_reg);
            post_fail_reg <= post_fail_next;
            diag_fail_reg <= diag_fail_next;
            lamp_out <= lamp_next;
            host_rd_valid_out <= host_rd_en_in;
        end
    end

    assign fault_flags_out = faults_reg;

    // ----------------------------------------------------------------
    // Result memory shared with the host
    // ----------------------------------------------------------------
    mcs_result_ram #(
        .DEPTH(NUM_CH),
        .AW(CH_W),
        .DW(SAMPLE_W)
    ) u_ram (
        .clk_in(clk_in),
        .wr_en_in(storing & ~cal_mode_reg),
        .wr_addr_in(chan_reg),
        .wr_data_in(corr_val),
        .rd_en_in(host_rd_en_in),
        .rd_addr_in(host_rd_addr_in),
        .rd_data_out(host_rd_data_out)
    );
endmodule : mcs_scanner
`default_nettype wire

// ### mcs_scanner_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_scanner_checker #(
    parameter int CAL_CYCLES = mcs_pkg::CAL_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic board_fault_in,
    input wire logic lamp_on_in,
    input wire logic diag_fail_in,
    input wire logic init_done_in,
    input wire logic [mcs_pkg::NUM_CH-1:0] fault_clr_in,
    input wire logic host_rd_en_in,
    input wire logic host_rd_valid_out,
    input wire logic [mcs_pkg::CH_W-1:0] chan_sel_out,
    input wire logic [mcs_pkg::NUM_CH-1:0] ref_sel_out,
    input wire logic conv_start_out,
    input wire logic [mcs_pkg::NUM_CH-1:0] fault_flags_out,
    input wire logic lamp_out
);
    import mcs_pkg::*;
    logic init_seen_reg;
    logic diag_seen_reg;
    // ----------------------------------------
    // Host handshake history
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            init_seen_reg <= 1'b0;
            diag_seen_reg <= 1'b0;
        end
        else
        begin
            init_seen_reg <= !lamp_on_in && (init_seen_reg || init_done_in);
            diag_seen_reg <= diag_seen_reg || diag_fail_in;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    reset_lamp_a:
        assert property (disable iff (1'b0) sys_rst_in |-> lamp_out &&
            !conv_start_out && fault_flags_out == '0)
        else $error("outputs wrong during reset");
    read_answer_a:
        assert property (host_rd_valid_out == $past(host_rd_en_in))
        else $error("read valid not one cycle after request");
    conv_hold_a:
        assert property (conv_start_out |=> (!conv_start_out &&
            $stable(chan_sel_out) && $stable(ref_sel_out))[*3])
        else $error("selection moved during conversion");
    fault_lamp_a:
        assert property ((fault_flags_out != '0)[*2] |-> lamp_out)
        else $error("lamp dark with channel fault");
    board_lamp_a:
        assert property (board_fault_in[*5] |-> lamp_out)
        else $error("lamp dark with board fault");
    fault_hold_a:
        assert property (!$past(init_done_in) |-> ($past(fault_flags_out) &
            ~$past(fault_clr_in) & ~fault_flags_out) == '0)
        else $error("fault flag dropped without clear");
    lamp_release_a:
        assert property ($fell(lamp_out) |-> init_seen_reg &&
            fault_flags_out == '0 && !diag_seen_reg)
        else $error("lamp went dark too early");
    diag_lamp_a:
        assert property (diag_seen_reg && $past(diag_seen_reg, 2) |-> lamp_out)
        else $error("lamp dark after failed diagnostic");
    cover property (conv_start_out && ref_sel_out == '0);
    cover property ($rose(fault_flags_out != '0));
    cover property ($fell(lamp_out));
endmodule : mcs_scanner_checker
bind mcs_scanner mcs_scanner_checker #(.CAL_CYCLES(CAL_CYCLES))
    u_mcs_scanner_checker (
    .clk_in, .sys_rst_in, .board_fault_in, .lamp_on_in, .diag_fail_in,
    .init_done_in, .fault_clr_in, .host_rd_en_in, .host_rd_valid_out,
    .chan_sel_out, .ref_sel_out, .conv_start_out, .fault_flags_out, .lamp_out
);
`default_nettype wire

// ### mcs_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_conv_model #(
    parameter logic [15:0] REF_CODE = 16'h4400,
    parameter logic [15:0] BAD_CODE = 16'h3000
) (
    input wire logic clk_in,
    input wire logic conv_start_in,
    input wire logic [2:0] chan_sel_in,
    input wire logic [7:0] ref_sel_in,
    input wire logic [15:0] field_in,
    input wire logic [7:0] bad_mask_in,
    input wire logic slow_in,
    output logic [15:0] adc_data_out,
    output logic adc_valid_out
);
    logic [2:0] ch;
    // ----------------------------------------
    // Converter answer, data set before valid
    // ----------------------------------------
    initial
    begin
        adc_valid_out = 1'b0;
        adc_data_out = 16'h5a5a;
        forever
        begin
            @(posedge clk_in);
            if (conv_start_in === 1'b1)
            begin
                ch = chan_sel_in;
                repeat (slow_in ? 9 : 1) @(posedge clk_in);
                #1;
                if (ref_sel_in[ch])
                    adc_data_out = bad_mask_in[ch] ? BAD_CODE : REF_CODE;
                else
                    adc_data_out = field_in + 16'(ch);
                @(posedge clk_in);
                #1;
                adc_valid_out = 1'b1;
                repeat (4) @(posedge clk_in);
                #1;
                adc_valid_out = 1'b0;
                adc_data_out = ~adc_data_out;
            end
        end
    end
endmodule : mcs_conv_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITFOR(c) begin k = 0; while (!(c) && k < 3000) begin \
    @(posedge clk_in); #1; k++; end if (k >= 3000) begin num_errors++; \
    $display("[ERR] wait exp 1 got 0"); close_out(); end end
module tb;
    import mcs_pkg::*;
    localparam logic [15:0] REF_CODE = 16'h4400;
    localparam logic [15:0] FIELD = 16'h2345;
    int num_errors = 0;
    int n_compared = 0;
    int k;
    logic clk_in, adc_valid_in, conv_start_out, lamp_out, host_rd_valid_out;
    logic sys_rst_in = 1'b0, board_fault_in = 1'b0, cfg_we_in = 1'b0;
    logic key_valid_in = 1'b0, lamp_on_in = 1'b0, diag_fail_in = 1'b0;
    logic init_done_in = 1'b0, host_rd_en_in = 1'b0, slow = 1'b0;
    logic [2:0] cfg_chan_in = 3'h0, cfg_group_in = 3'h0;
    logic [2:0] host_rd_addr_in = 3'h0, chan_sel_out;
    logic [7:0] key_in = 8'h00, fault_clr_in = 8'h00, bad_mask = 8'h00;
    logic [7:0] ref_sel_out, fault_flags_out;
    logic [15:0] cfg_lim_lo_in = 16'h3800, cfg_lim_hi_in = 16'h4800;
    logic [15:0] adc_data_in, host_rd_data_out;
    mcs_scanner #(.CAL_CYCLES(200)) u_mcs_scanner (
        .clk_in, .sys_rst_in, .adc_data_in, .adc_valid_in, .board_fault_in,
        .cfg_we_in, .cfg_chan_in, .cfg_group_in, .cfg_lim_lo_in,
        .cfg_lim_hi_in, .key_valid_in, .key_in, .lamp_on_in, .diag_fail_in,
        .init_done_in, .fault_clr_in, .host_rd_en_in, .host_rd_addr_in,
        .host_rd_data_out, .host_rd_valid_out, .chan_sel_out, .ref_sel_out,
        .conv_start_out, .fault_flags_out, .lamp_out
    );
    mcs_conv_model #(.REF_CODE(REF_CODE)) u_mcs_conv_model (
        .clk_in, .conv_start_in(conv_start_out), .chan_sel_in(chan_sel_out),
        .ref_sel_in(ref_sel_out), .field_in(FIELD), .bad_mask_in(bad_mask),
        .slow_in(slow), .adc_data_out(adc_data_in),
        .adc_valid_out(adc_valid_in)
    );
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task close_out;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    function automatic logic [15:0] corr(input logic [15:0] raw);
        logic [31:0] sc, v;
        sc = 32'h8000 - REF_CODE;
        v = ((raw * sc) >> 14) + 32'h4000 - ((REF_CODE * sc) >> 14);
        return (v > 32'hffff) ? 16'hffff : v[15:0];
    endfunction : corr
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_selftest;
        `CHK("lamp_in_reset", 1'b1, lamp_out)
        sys_rst_in = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            step(1);
            `WAITFOR(conv_start_out === 1'b1)
            `CHK("cal_chan", 3'(i), chan_sel_out)
            `CHK("cal_ref_sel", 8'hff, ref_sel_out)
        end
    endtask : t_selftest
    task t_key;
        int n;
        logic [2:0] want [2];
        want = '{3'h2, 3'h5};
        cfg_we_in = 1'b1;
        for (int i = 0; i < NUM_CH; i++)
        begin
            cfg_chan_in = 3'(i);
            cfg_group_in = 3'(i);
            step(1);
        end
        cfg_we_in = 1'b0;
        slow = 1'b1;
        key_in = 8'h24;
        key_valid_in = 1'b1;
        step(1);
        key_valid_in = 1'b0;
        n = 0;
        while (n < 2)
        begin
            step(1);
            `WAITFOR(conv_start_out === 1'b1)
            if (ref_sel_out === 8'h00)
            begin
                `CHK("key_chan", want[n], chan_sel_out)
                n++;
            end
        end
        n = 0;
        repeat (150)
        begin
            step(1);
            if (conv_start_out === 1'b1 && ref_sel_out === 8'h00)
                n++;
        end
        `CHK("extra_convs", 0, n)
        for (int i = 0; i < 2; i++)
        begin
            host_rd_en_in = 1'b1;
            host_rd_addr_in = want[i];
            step(1);
            host_rd_en_in = 1'b0;
            `CHK("rd_valid", 1'b1, host_rd_valid_out)
            `CHK("rd_data", corr(FIELD + 16'(want[i])), host_rd_data_out)
            step(1);
        end
    endtask : t_key
    task t_lamp;
        lamp_on_in = 1'b1;
        step(1);
        lamp_on_in = 1'b0;
        step(10);
        `CHK("lamp_before_init", 1'b1, lamp_out)
        init_done_in = 1'b1;
        step(1);
        init_done_in = 1'b0;
        `WAITFOR(lamp_out === 1'b0)
        bad_mask = 8'h10;
        `WAITFOR(fault_flags_out !== 8'h00)
        `CHK("fault_flags", 8'h10, fault_flags_out)
        bad_mask = 8'h00;
        step(2);
        `CHK("lamp_fault", 1'b1, lamp_out)
        step(450);
        `CHK("fault_sticky", 8'h10, fault_flags_out)
        fault_clr_in = 8'h10;
        step(1);
        fault_clr_in = 8'h00;
        step(2);
        `CHK("fault_cleared", 8'h00, fault_flags_out)
        `CHK("lamp_clear", 1'b0, lamp_out)
        lamp_on_in = 1'b1;
        step(1);
        lamp_on_in = 1'b0;
        step(1);
        `CHK("lamp_forced", 1'b1, lamp_out)
        init_done_in = 1'b1;
        step(1);
        init_done_in = 1'b0;
        `WAITFOR(lamp_out === 1'b0)
        board_fault_in = 1'b1;
        step(6);
        `CHK("lamp_board", 1'b1, lamp_out)
        board_fault_in = 1'b0;
        diag_fail_in = 1'b1;
        step(1);
        diag_fail_in = 1'b0;
        init_done_in = 1'b1;
        step(1);
        init_done_in = 1'b0;
        step(20);
        `CHK("lamp_diag", 1'b1, lamp_out)
        sys_rst_in = 1'b1;
        step(2);
        sys_rst_in = 1'b0;
        step(1);
        `CHK("rst_ref_sel", 8'hff, ref_sel_out)
        step(1);
        `CHK("rst_cal_start", 1'b1, conv_start_out)
        `CHK("rst_cal_chan", 3'h0, chan_sel_out)
        step(300);
        `CHK("lamp_no_init", 1'b1, lamp_out)
    endtask : t_lamp
    initial
    begin
        // Raise reset after time zero so the asynchronous reset sees an edge
        #1;
        sys_rst_in = 1'b1;
        step(16);
        t_selftest();
        t_key();
        t_lamp();
        close_out();
    end
    initial
    begin
        #(40 * 50000);
        num_errors++;
        close_out();
    end
endmodule : tb
`default_nettype wire
